// *** rtl/spma_defs.vh ***
// Constants for the selector port memory access block.
`ifndef SPMA_DEFS_VH
`define SPMA_DEFS_VH

// ----------------------------------------------------------------
// Memory bus identity and codes
// ----------------------------------------------------------------
`define SPMA_SOURCE_ID      3'h4
`define SPMA_OP_READ        1'b0
`define SPMA_OP_WRITE       1'b1
`define SPMA_TABLE_SHIFT    2

// ----------------------------------------------------------------
// APB register byte offsets
// ----------------------------------------------------------------
`define SPMA_REG_COMMAND    12'h000
`define SPMA_REG_STATUS     12'h004
`define SPMA_REG_PCOUNT     12'h008
`define SPMA_REG_CMDWORD    12'h00c
`define SPMA_REG_ADDRWORD   12'h010
`define SPMA_REG_CONFIG     12'h014

// ----------------------------------------------------------------
// Command register fields and codes
// ----------------------------------------------------------------
`define SPMA_CMD_CODE_LSB   0
`define SPMA_CMD_CODE_MSB   1
`define SPMA_CMD_DEV_LSB    8
`define SPMA_CMD_DEV_MSB    15
`define SPMA_CMD_TEST       2'h1
`define SPMA_CMD_START      2'h2

// ----------------------------------------------------------------
// Status register fields and reset values
// ----------------------------------------------------------------
`define SPMA_ST_ALLOWED     0
`define SPMA_ST_ACTIVE      1
`define SPMA_ST_SVC_IN      2
`define SPMA_ST_FETCHED     3
`define SPMA_DEV_RESET      8'h00
`define SPMA_WORD_RESET     16'h0000

`endif

// *** rtl/spma_port.v ***
// One channel port of the memory bus arbiter.
`timescale 1ns/100ps
`include "spma_defs.vh"

module spma_port #(
    parameter AW = 16,
    parameter DW = 16
) (
    // Clock and reset
    input  wire          pclk,
    input  wire          presetn,
    // Channel side
    input  wire          new_req,
    input  wire          req_write,
    input  wire [1:0]    req_dest,
    input  wire [AW-1:0] req_addr,
    input  wire [DW-1:0] req_data,
    // Arbiter side
    input  wire          grant_low,
    input  wire          grant_high,
    input  wire          ret_valid,
    input  wire [2:0]    ret_to,
    input  wire [1:0]    ret_from,
    // State
    output reg           address_phase_request,
    output reg           data_phase_request,
    output reg           memory_operation_code,
    output reg  [1:0]    dest,
    output reg  [AW-1:0] addr,
    output reg  [DW-1:0] data,
    output reg           wait_return,
    output reg           address_phase_grant_pulse,
    output reg           hsel_pulse,
    output reg           read_return_strobe,
    output wire          busy,
    output wire          ret_hit
);

    assign busy    = address_phase_request | data_phase_request | wait_return;
    // A return is ours only when both the source and destination compare.
    assign ret_hit = wait_return & ret_valid & (ret_to == `SPMA_SOURCE_ID)
                     & (ret_from == dest);

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            address_phase_request <= 1'b0;
            data_phase_request    <= 1'b0;
            memory_operation_code <= `SPMA_OP_READ;
            dest                  <= 2'h0;
            addr                  <= {AW{1'b0}};
            data                  <= {DW{1'b0}};
            wait_return           <= 1'b0;
            address_phase_grant_pulse            <= 1'b0;
            hsel_pulse            <= 1'b0;
            read_return_strobe    <= 1'b0;
        end else begin
            address_phase_grant_pulse         <= grant_low;
            hsel_pulse         <= grant_high;
            read_return_strobe <= ret_hit;
            // A port busy with a request ignores new ones so its fields stay stable.
            if (new_req && !busy) begin
                address_phase_request <= 1'b1;
                memory_operation_code <= req_write;
                dest                  <= req_dest;
                addr                  <= req_addr;
                data                  <= req_data;
            end
            if (grant_low) begin
                address_phase_request <= 1'b0;
                if (memory_operation_code == `SPMA_OP_WRITE)
                    data_phase_request <= 1'b1;
                else
                    wait_return <= 1'b1;
            end
            if (grant_high)
                data_phase_request <= 1'b0;
            if (ret_hit)
                wait_return <= 1'b0;
        end
    end

endmodule // spma_port

// *** rtl/spma_top.v ***
// Selector channel, device controller face and three-port memory bus arbiter.
`timescale 1ns/100ps
`include "spma_defs.vh"

module spma_top #(
    parameter AW = 16,
    parameter DW = 16
) (
    // Clock and reset
    input  wire          pclk,
    input  wire          presetn,
    // APB slave
    input  wire          psel,
    input  wire          penable,
    input  wire          pwrite,
    input  wire [11:0]   paddr,
    input  wire [31:0]   pwdata,
    output reg  [31:0]   prdata,
    output reg           pready,
    output reg           pslverr,
    // Device side
    input  wire          device_ready,
    output reg           channel_service_out,
    output reg           device_selected,
    output reg  [15:0]   service_request_lines,
    // External channel ports 3 and 4
    input  wire [1:0]    ext_req,
    input  wire [1:0]    ext_write,
    input  wire [3:0]    ext_dest,
    input  wire [2*AW-1:0] ext_addr,
    input  wire [2*DW-1:0] ext_data,
    output reg  [1:0]    ext_address_phase_grant,
    output reg  [1:0]    ext_data_phase_grant,
    output reg  [1:0]    ext_read_return_strobe,
    output reg  [1:0]    ext_busy,
    output reg  [DW-1:0] port_data_lines,
    // Memory control bus
    input  wire          bus_enable,
    input  wire [3:0]    mem_ready,
    input  wire          ret_valid,
    input  wire [2:0]    ret_to,
    input  wire [1:0]    ret_from,
    input  wire [DW-1:0] ret_data,
    output reg           mem_valid,
    output reg  [AW-1:0] mem_word,
    output reg  [1:0]    mem_to,
    output reg  [2:0]    mem_from,
    output reg           mem_op,
    output reg  [3:0]    mem_ready_pull
);

    // ----------------------------------------------------------------
    // Channel states
    // ----------------------------------------------------------------
    localparam [5:0] ST_IDLE  = 6'b000001;
    localparam [5:0] ST_BASE  = 6'b000010;
    localparam [5:0] ST_TABLE = 6'b000100;
    localparam [5:0] ST_CW    = 6'b001000;
    localparam [5:0] ST_AW    = 6'b010000;
    localparam [5:0] ST_EXEC  = 6'b100000;

    reg  [5:0]    state;
    reg  [5:0]    next_state;
    reg           active;
    reg           issued;
    reg           allowed;
    reg           svc_in;
    reg  [7:0]    own_device;
    reg  [7:0]    reserved_device;
    reg  [1:0]    fetch_dest;
    reg  [AW-1:0] table_addr;
    reg  [AW-1:0] pcount;
    reg  [DW-1:0] cmd_word;
    reg  [DW-1:0] addr_word;

    // ----------------------------------------------------------------
    // Ports, index 0 = channel 1, 1 = channel 3, 2 = channel 4
    // ----------------------------------------------------------------
    wire [2:0]    p_new;
    wire [2:0]    p_write;
    wire [5:0]    p_rdest;
    wire [3*AW-1:0] p_raddr;
    wire [3*DW-1:0] p_rdata;
    wire [2:0]    p_address_phase_request;
    wire [2:0]    p_data_phase_request;
    wire [2:0]    p_op;
    wire [5:0]    p_dest;
    wire [3*AW-1:0] p_addr;
    wire [3*DW-1:0] p_data;
    wire [2:0]    p_address_phase_grant;
    wire [2:0]    p_hsel;
    wire [2:0]    p_read_return_strobe;
    wire [2:0]    p_busy;
    wire [2:0]    p_hit;
    reg  [2:0]    g_low;
    reg  [2:0]    g_high;
    wire [2:0]    low_ok;
    wire          chan_need;

    assign chan_need = !issued && !p_busy[0] && (state == ST_TABLE || state == ST_CW
                       || state == ST_AW);
    assign p_new   = {ext_req, chan_need};
    assign p_write = {ext_write, `SPMA_OP_READ};
    assign p_rdest = {ext_dest, fetch_dest};
    assign p_raddr = {ext_addr, (state == ST_TABLE) ? table_addr : pcount};
    assign p_rdata = {ext_data, {DW{1'b0}}};

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1) begin : g_port
            // Identical logic per port.
            spma_port #(.AW(AW), .DW(DW)) u_port (
                .pclk                  (pclk),
                .presetn               (presetn),
                .new_req               (p_new[gi]),
                .req_write             (p_write[gi]),
                .req_dest              (p_rdest[2*gi+1:2*gi]),
                .req_addr              (p_raddr[AW*gi+AW-1:AW*gi]),
                .req_data              (p_rdata[DW*gi+DW-1:DW*gi]),
                .grant_low             (g_low[gi]),
                .grant_high            (g_high[gi]),
                .ret_valid             (ret_valid),
                .ret_to                (ret_to),
                .ret_from              (ret_from),
                .address_phase_request (p_address_phase_request[gi]),
                .data_phase_request    (p_data_phase_request[gi]),
                .memory_operation_code (p_op[gi]),
                .dest                  (p_dest[2*gi+1:2*gi]),
                .addr                  (p_addr[AW*gi+AW-1:AW*gi]),
                .data                  (p_data[DW*gi+DW-1:DW*gi]),
                .wait_return           (),
                .address_phase_grant_pulse            (p_address_phase_grant[gi]),
                .hsel_pulse            (p_hsel[gi]),
                .read_return_strobe    (p_read_return_strobe[gi]),
                .busy                  (p_busy[gi]),
                .ret_hit               (p_hit[gi])
            );
            // Ready of the requested module gates the address phase.
            assign low_ok[gi] = p_address_phase_request[gi] & mem_ready[p_dest[2*gi+1:2*gi]];
        end
    endgenerate

    // ----------------------------------------------------------------
    // Fixed priority arbiter, at most one grant per enabled cycle with mem_valid low
    // ----------------------------------------------------------------
    always @* begin
        g_low  = 3'b000;
        g_high = 3'b000;
        if (bus_enable && !mem_valid) begin
            if (p_data_phase_request[0])
                g_high = 3'b001;
            else if (p_data_phase_request[1])
                g_high = 3'b010;
            else if (p_data_phase_request[2])
                g_high = 3'b100;
            else if (low_ok[0])
                g_low = 3'b001;
            else if (low_ok[1])
                g_low = 3'b010;
            else if (low_ok[2])
                g_low = 3'b100;
        end
    end

    // ----------------------------------------------------------------
    // Memory bus drive, one cycle per transmission
    // ----------------------------------------------------------------
    integer k;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_valid      <= 1'b0;
            mem_word       <= {AW{1'b0}};
            mem_to         <= 2'h0;
            mem_from       <= `SPMA_SOURCE_ID;
            mem_op         <= `SPMA_OP_READ;
            mem_ready_pull <= 4'h0;
        end else begin
            mem_valid      <= |(g_low | g_high);
            mem_from       <= `SPMA_SOURCE_ID;
            mem_ready_pull <= 4'h0;
            for (k = 0; k < 3; k = k + 1) begin
                if (g_low[k]) begin
                    mem_word <= p_addr[AW*k +: AW];
                    mem_to   <= p_dest[2*k +: 2];
                    mem_op   <= p_op[k];
                    mem_ready_pull[p_dest[2*k +: 2]] <= 1'b1;
                end
                if (g_high[k]) begin
                    mem_word <= p_data[DW*k +: DW];
                    mem_to   <= p_dest[2*k +: 2];
                    mem_op   <= p_op[k];
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Channel port outputs and returned data
    // ----------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_address_phase_grant <= 2'b00;
            ext_data_phase_grant    <= 2'b00;
            ext_read_return_strobe  <= 2'b00;
            ext_busy                <= 2'b00;
            port_data_lines         <= {DW{1'b0}};
        end else begin
            ext_address_phase_grant <= g_low[2:1];
            ext_data_phase_grant    <= g_high[2:1];
            ext_read_return_strobe  <= p_hit[2:1];
            ext_busy                <= p_busy[2:1] | ext_req;
            if (|p_hit)
                port_data_lines <= ret_data;
        end
    end

    // ----------------------------------------------------------------
    // Selector channel and device controller
    // ----------------------------------------------------------------
    wire          apb_wr;
    wire          apb_wr_req;
    wire          apb_rd;
    wire [1:0]    cmd_code;
    wire [7:0]    cmd_dev;
    wire          dev_match;

    // A write lands on the edge that completes the transfer, with pready high.
    assign apb_wr    = psel & penable & pwrite & pready;
    assign apb_wr_req = psel & penable & pwrite & !pready;
    assign apb_rd    = psel & penable & !pwrite & !pready;
    assign cmd_code  = pwdata[`SPMA_CMD_CODE_MSB:`SPMA_CMD_CODE_LSB];
    assign cmd_dev   = pwdata[`SPMA_CMD_DEV_MSB:`SPMA_CMD_DEV_LSB];
    assign dev_match = (cmd_dev == own_device);

    always @* begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                // One program for one device; a start while active is ignored.
                if (apb_wr && paddr == `SPMA_REG_COMMAND && cmd_code == `SPMA_CMD_START
                    && dev_match && !active)
                    next_state = ST_BASE;
            end
            ST_BASE:  next_state = ST_TABLE;
            ST_TABLE: if (p_read_return_strobe[0]) next_state = ST_CW;
            ST_CW:    if (p_read_return_strobe[0]) next_state = ST_AW;
            ST_AW:    if (p_read_return_strobe[0]) next_state = ST_EXEC;
            ST_EXEC:  next_state = ST_EXEC;
            default:  next_state = ST_IDLE;
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state                 <= ST_IDLE;
            active                <= 1'b0;
            issued                <= 1'b0;
            allowed               <= 1'b0;
            svc_in                <= 1'b0;
            own_device            <= `SPMA_DEV_RESET;
            reserved_device       <= `SPMA_DEV_RESET;
            fetch_dest            <= 2'h0;
            table_addr            <= {AW{1'b0}};
            pcount                <= {AW{1'b0}};
            cmd_word              <= `SPMA_WORD_RESET;
            addr_word             <= `SPMA_WORD_RESET;
            channel_service_out   <= 1'b0;
            device_selected       <= 1'b0;
            service_request_lines <= 16'h0000;
        end else begin
            state <= next_state;
            if (chan_need)
                issued <= 1'b1;
            if (p_read_return_strobe[0])
                issued <= 1'b0;
            if (apb_wr && paddr == `SPMA_REG_CONFIG) begin
                own_device <= pwdata[`SPMA_CMD_DEV_MSB:`SPMA_CMD_DEV_LSB];
                fetch_dest <= pwdata[1:0];
            end
            if (apb_wr && paddr == `SPMA_REG_COMMAND && cmd_code == `SPMA_CMD_TEST
                && dev_match)
                allowed <= device_ready & !active;
            if (state == ST_IDLE && next_state == ST_BASE) begin
                active          <= 1'b1;
                svc_in          <= 1'b1;
                reserved_device <= cmd_dev;
                // Sixteen shared lines carry the shifted device number.
                service_request_lines <= {8'h00, cmd_dev} << `SPMA_TABLE_SHIFT;
            end
            if (state == ST_BASE)
                table_addr <= service_request_lines[AW-1:0];
            if (p_address_phase_grant[0] && state != ST_TABLE)
                pcount <= pcount + {{(AW-1){1'b0}}, 1'b1};
            if (state == ST_TABLE && p_read_return_strobe[0])
                pcount <= port_data_lines;
            if (state == ST_CW && p_read_return_strobe[0])
                cmd_word <= port_data_lines;
            if (state == ST_AW && p_read_return_strobe[0])
                addr_word <= port_data_lines;
            channel_service_out <= active;
            device_selected     <= active && (reserved_device == own_device);
        end
    end

    // ----------------------------------------------------------------
    // APB answer, one wait state on every access
    // ----------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel & penable & !pready;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
            if (apb_rd) begin
                if (paddr == `SPMA_REG_COMMAND)
                    prdata <= 32'h0000_0000;
                else if (paddr == `SPMA_REG_STATUS)
                    prdata <= {24'h00_0000, 2'b00, state == ST_EXEC ? 6'h08 : 6'h00}
                              | {29'h0000_0000, svc_in, active, allowed};
                else if (paddr == `SPMA_REG_PCOUNT)
                    prdata <= {{(32-AW){1'b0}}, pcount};
                else if (paddr == `SPMA_REG_CMDWORD)
                    prdata <= {{(32-DW){1'b0}}, cmd_word};
                else if (paddr == `SPMA_REG_ADDRWORD)
                    prdata <= {{(32-DW){1'b0}}, addr_word};
                else if (paddr == `SPMA_REG_CONFIG)
                    prdata <= {16'h0000, own_device, 6'h00, fetch_dest};
                else
                    pslverr <= 1'b1;
            end else if (apb_wr_req && paddr != `SPMA_REG_COMMAND && paddr != `SPMA_REG_CONFIG)
                pslverr <= 1'b1;
        end
    end

endmodule // spma_top

// *** testbench/spma_mem_model.sv ***
// Behavioural memory modules answering the arbiter on the control bus.
`timescale 1ns/100ps
module spma_mem_model (
    // Clock and stall control
    input  wire         pclk,
    input  wire  [4:0]  stall,
    // Control bus from the arbiter
    input  wire         mem_valid,
    input  wire  [15:0] mem_word,
    input  wire  [1:0]  mem_to,
    input  wire         mem_op,
    input  wire  [3:0]  mem_ready_pull,
    // Answers to the arbiter
    output logic        bus_enable,
    output logic [3:0]  mem_ready,
    output logic        ret_valid,
    output logic [2:0]  ret_to,
    output logic [1:0]  ret_from,
    output logic [15:0] ret_data
);
    logic [17:0] pend[$];
    int          due[$];
    int          cyc = 0;
    assign bus_enable = !stall[4];
    assign mem_ready  = ~stall[3:0] & ~mem_ready_pull;
    initial begin
        {ret_valid, ret_to, ret_from, ret_data} = '0;
    end
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (mem_valid && mem_op == 1'b0) begin
            pend.push_back({mem_to, mem_word});
            due.push_back(cyc + 4);
        end
        if (due.size() > 0 && due[0] <= cyc) begin
            ret_valid <= 1'b1;
            ret_to    <= 3'h4;
            ret_from  <= pend[0][17:16];
            ret_data  <= pend[0][15:0] ^ 16'h5a5a;
            void'(pend.pop_front());
            void'(due.pop_front());
        end else begin
            // Idle ret_to and ret_data toggle so a stale word can never pass for a return.
            ret_valid <= 1'b0;
            ret_to    <= ~ret_to;
            ret_data  <= ~ret_data;
        end
    end
endmodule // spma_mem_model

// *** testbench/spma_top_sva.sv ***
// Checker for the memory bus side of the port arbiter.
`timescale 1ns/100ps
module spma_top_sva (
    input wire       pclk,
    input wire       presetn,
    input wire       pready,
    input wire       bus_enable,
    input wire       ret_valid,
    input wire [2:0] ret_to,
    input wire [1:0] ret_from,
    input wire [3:0] ext_dest,
    input wire [1:0] ext_read_return_strobe,
    input wire [1:0] ext_address_phase_grant,
    input wire [1:0] ext_data_phase_grant,
    input wire       mem_valid,
    input wire       mem_op,
    input wire [1:0] mem_to,
    input wire [2:0] mem_from,
    input wire [3:0] mem_ready_pull
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    src_id_a: assert property (mem_from == 3'h4)
        else $error("wrong source id");
    bus_gap_a: assert property (mem_valid |=> !mem_valid)
        else $error("back to back send");
    enb_cause_a: assert property ($rose(mem_valid) |-> $past(bus_enable))
        else $error("send without enable");
    pull_dest_a: assert property (|mem_ready_pull |-> mem_valid && mem_ready_pull == 4'h1 << mem_to)
        else $error("wrong ready pulled");
    data_op_a: assert property (|ext_data_phase_grant |-> mem_valid && mem_op)
        else $error("data send not write");
    addr_pull_a: assert property (|ext_address_phase_grant |-> mem_valid && |mem_ready_pull)
        else $error("address send odd");
    strobe_three_a: assert property (ext_read_return_strobe[0] |->
        $past(ret_valid && ret_to == 3'h4 && ret_from == ext_dest[1:0]))
        else $error("strobe without match");
    strobe_four_a: assert property (ext_read_return_strobe[1] |->
        $past(ret_valid && ret_to == 3'h4 && ret_from == ext_dest[3:2]))
        else $error("strobe without match");
    pready_pulse_a: assert property (pready |=> !pready)
        else $error("ready too long");
endmodule // spma_top_sva

// *** testbench/spma_top_tb_top.sv ***
// Self-checking bench for the selector port memory access block.
`timescale 1ns/100ps
`include "spma_defs.vh"
module spma_top_tb_top;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic        device_ready, channel_service_out, device_selected;
    logic        bus_enable, ret_valid, mem_valid, mem_op;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rv, ext_addr, ext_data;
    logic [15:0] service_request_lines, port_data_lines, mem_word, ret_data;
    logic [1:0]  ext_req, ext_write, ext_address_phase_grant, ext_data_phase_grant;
    logic [1:0]  ext_read_return_strobe, ext_busy, mem_to, ret_from;
    logic [3:0]  ext_dest, mem_ready, mem_ready_pull;
    logic [2:0]  ret_to, mem_from;
    logic [4:0]  stall;
    logic [18:0] log_q[$];
    logic [15:0] rd[2];
    int          num_errors = 0;
    int          checks = 0;
    spma_top DUT (.*);
    spma_mem_model mem_u (.*);
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        if (mem_valid === 1'b1)
            log_q.push_back({mem_op, mem_to, mem_word});
        for (int i = 0; i < 2; i++)
            if (ext_read_return_strobe[i] === 1'b1)
                rd[i] = port_data_lines;
    end
    task automatic tally_and_finish;
        if (num_errors == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic hang(input int n);
        if (n > 100) begin
            num_errors++;
            tally_and_finish;
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            hang(++n);
        end while (pready !== 1'b1);
        rv = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task automatic ext_set(input int i, input logic w, input logic [1:0] m,
                           input logic [15:0] a, input logic [15:0] d);
        ext_req[i] <= 1'b1;
        ext_write[i] <= w;
        ext_dest[2*i +: 2] <= m;
        ext_addr[16*i +: 16] <= a;
        ext_data[16*i +: 16] <= d;
    endtask
    task automatic go_wait(input logic [1:0] m);
        int n;
        n = 0;
        @(posedge pclk);
        ext_req <= 2'b00;
        do begin
            @(posedge pclk);
            hang(++n);
        end while ((ext_busy & m) !== 2'b00);
        @(posedge pclk);
    endtask
    task automatic s_regs;
        apb(1'b1, `SPMA_REG_CONFIG, 32'h0000_0302);
        apb(1'b0, `SPMA_REG_CONFIG, 32'h0000_0000);
        chk(rv, 32'h0000_0302);
        chk(err, 1'b0);
        apb(1'b0, 12'h040, 32'h0000_0000);
        chk(err, 1'b1);
        apb(1'b1, `SPMA_REG_STATUS, 32'h0000_000f);
        chk(err, 1'b1);
    endtask
    task automatic s_test(input logic rdy, input logic act);
        device_ready <= rdy;
        apb(1'b1, `SPMA_REG_COMMAND, 32'h0000_0301);
        apb(1'b0, `SPMA_REG_STATUS, 32'h0000_0000);
        chk(rv[0], rdy & !act);
    endtask
    task automatic s_start;
        int n;
        n = 0;
        log_q.delete();
        apb(1'b1, `SPMA_REG_COMMAND, 32'h0000_0302);
        do begin
            apb(1'b0, `SPMA_REG_STATUS, 32'h0000_0000);
            hang(++n);
        end while (rv[3] !== 1'b1);
        chk(rv[3:1], 3'h7);
        chk({channel_service_out, device_selected}, 2'b11);
        chk(service_request_lines, 16'h000c);
        chk(log_q.size(), 3);
        chk(log_q[0], {3'b010, 16'h000c});
        chk(log_q[1], {3'b010, 16'h5a56});
        chk(log_q[2], {3'b010, 16'h5a57});
        apb(1'b0, `SPMA_REG_PCOUNT, 32'h0000_0000);
        chk(rv, 32'h0000_5a58);
        apb(1'b0, `SPMA_REG_CMDWORD, 32'h0000_0000);
        chk(rv, 32'h0000_000c);
        apb(1'b0, `SPMA_REG_ADDRWORD, 32'h0000_0000);
        chk(rv, 32'h0000_000d);
    endtask
    task automatic s_write;
        logic [15:0] e[4];
        e = '{16'h0100, 16'h0111, 16'h0200, 16'h0222};
        log_q.delete();
        stall <= 5'h10;
        ext_set(0, 1'b1, 2'h1, 16'h1234, 16'hbeef);
        @(posedge pclk);
        ext_req <= 2'b00;
        repeat (4) @(posedge pclk);
        chk(log_q.size(), 0);
        stall <= 5'h00;
        go_wait(2'b11);
        chk(log_q[0], {3'b101, 16'h1234});
        chk(log_q[1], {3'b101, 16'hbeef});
        log_q.delete();
        ext_set(0, 1'b1, 2'h0, e[0], e[1]);
        ext_set(1, 1'b1, 2'h1, e[2], e[3]);
        go_wait(2'b11);
        chk(log_q.size(), 4);
        for (int i = 0; i < 4; i++)
            chk(log_q[i][15:0], e[i]);
    endtask
    task automatic s_read;
        log_q.delete();
        stall <= 5'h01;
        ext_set(0, 1'b0, 2'h0, 16'h0300, 16'h0000);
        ext_set(1, 1'b0, 2'h1, 16'h0400, 16'h0000);
        go_wait(2'b10);
        chk(log_q[0], {3'b001, 16'h0400});
        chk(rd[1], 16'h0400 ^ 16'h5a5a);
        stall <= 5'h00;
        go_wait(2'b11);
        chk(rd[0], 16'h0300 ^ 16'h5a5a);
    endtask
    initial begin
        {psel, penable, pwrite, paddr, pwdata, device_ready} = '0;
        {ext_req, ext_write, ext_dest, ext_addr, ext_data, stall} = '0;
        presetn = 1'b0;
        repeat (20) @(posedge pclk);
        chk(mem_from, 3'h4);
        presetn <= 1'b1;
        s_regs();
        s_test(1'b0, 1'b0);
        s_test(1'b1, 1'b0);
        s_start();
        s_test(1'b1, 1'b1);
        s_write();
        s_read();
        tally_and_finish();
    end
endmodule // spma_top_tb_top
bind spma_top spma_top_sva chk_u (.*);
